/* File: bench/fps_staging_tb.sv */
// testbench for the flash program staging block
// assumes one 250 MHz clock; bench plays bus master and flash controller
module fps_staging_tb
  import fps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----
  // stimulus and observed signals
  // ----
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bank, irq;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic start = 1'b0, stop = 1'b0, end_err = 1'b0;
  logic werr = 1'b0, suspend_flag = 1'b0;
  logic [SECT_N-1:0] fail = '0, sel;
  logic [20:0] paddr;
  logic [63:0] pdata;
  int num_errors = 0;
  int n_compared = 0;

  always #2 i_clock = ~i_clock;

  fps_staging fps_staging_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .i_erase_start(start), .i_erase_end(stop),
    .i_end_error(end_err), .i_sector_fail(fail),
    .i_write_error(werr), .i_suspend(suspend_flag), .o_prog_address(paddr),
    .o_prog_data(pdata), .o_sector_select(sel),
    .o_bank0_state(bank), .o_irq(irq)
  );

  // ----
  // shared tasks
  // ----
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // valid drops only at the edge that took it, never early
  task automatic wr(input logic [19:0] ix, input logic [15:0] d,
                    input logic [1:0] er);
    @(posedge i_clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= {ix, 2'b00};
    wdata <= {16'h0000, d};
    do
    begin
      @(posedge i_clock);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, er);
    #1;
  endtask

  task automatic rd(input logic [19:0] ix, input logic [15:0] e,
                    input logic [1:0] er);
    @(posedge i_clock);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= {ix, 2'b00};
    do
    begin
      @(posedge i_clock);
      arvalid <= arvalid & ~arready;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, {16'h0000, e});
    chk("rresp", rresp, er);
    #1;
  endtask

  // one-cycle start or end pulse; returns once the update has landed
  task automatic kick(input logic fin);
    @(posedge i_clock);
    start <= ~fin;
    stop <= fin;
    @(posedge i_clock);
    start <= 1'b0;
    stop <= 1'b0;
    #1;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    chk("pdata", pdata, 64'hffff_ffff_ffff_ffff);
    rd(IDX_DATA_B_LOW, 16'hffff, RESP_OKAY);
    rd(IDX_DATA_B_HIGH, 16'hffff, RESP_OKAY);
    rd(IDX_ADDR_LOW, 16'h0000, RESP_OKAY);
    chk("paddr", paddr, 21'h00_0000);
  endtask

  task automatic t_stage;
    wr(IDX_DATA_A_LOW, 16'h1234, RESP_OKAY);
    wr(IDX_DATA_A_HIGH, 16'h5678, RESP_OKAY);
    wr(IDX_DATA_B_LOW, 16'h9abc, RESP_OKAY);
    wr(IDX_DATA_B_HIGH, 16'hdef0, RESP_OKAY);
    chk("pdata", pdata, 64'hdef0_9abc_5678_1234);
    rd(IDX_DATA_B_LOW, 16'h9abc, RESP_OKAY);
    wr(IDX_ADDR_LOW, 16'hffff, RESP_OKAY);
    rd(IDX_ADDR_LOW, 16'hfffc, RESP_OKAY);
    wr(IDX_ADDR_HIGH, 16'hffff, RESP_OKAY);
    rd(IDX_ADDR_HIGH, 16'h001f, RESP_OKAY);
    chk("paddr", paddr, 21'h1f_fffc);
    wr(IDX_ADDR_LOW, 16'h1238, RESP_OKAY);
    chk("paddr", paddr, 21'h1f_1238);
    wr(20'h8_0020, 16'h0001, RESP_SLVERR);
    rd(20'h8_0020, 16'h0000, RESP_SLVERR);
  endtask

  task automatic t_erase;
    wr(IDX_IRQ_MASK, 16'h0007, RESP_OKAY);
    wr(IDX_STAT_LOW, 16'h00a5, RESP_OKAY);
    chk("select", sel, 8'ha5);
    kick(1'b0);
    chk("bank", bank, 1'b1);
    wr(IDX_STAT_LOW, 16'h0000, RESP_OKAY);
    chk("select", sel, 8'ha5);
    rd(IDX_STAT_HIGH, 16'h0100, RESP_OKAY);
    @(posedge i_clock);
    suspend_flag <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(IDX_FLAG_VIEW, 16'h000a, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 16'h0004, RESP_OKAY);
    @(posedge i_clock);
    suspend_flag <= 1'b0;
    kick(1'b1);
    chk("bank", bank, 1'b0);
    chk("select", sel, 8'h00);
    rd(IDX_IRQ_STATUS, 16'h0005, RESP_OKAY);
    chk("irq", irq, 1'b1);
    wr(IDX_IRQ_STATUS, 16'h0005, RESP_OKAY);
    chk("irq", irq, 1'b0);
  endtask

  // error end with the interrupt masked first, then unmasked
  task automatic t_fault;
    wr(IDX_IRQ_MASK, 16'h0000, RESP_OKAY);
    wr(IDX_STAT_LOW, 16'h00ff, RESP_OKAY);
    kick(1'b0);
    @(posedge i_clock);
    werr <= 1'b1;
    end_err <= 1'b1;
    fail <= 8'h3c;
    kick(1'b1);
    chk("bank", bank, 1'b1);
    chk("select", sel, 8'h3c);
    rd(IDX_FLAG_VIEW, 16'h0005, RESP_OKAY);
    chk("irq", irq, 1'b0);
    wr(IDX_IRQ_MASK, 16'h0002, RESP_OKAY);
    chk("irq", irq, 1'b1);
    @(posedge i_clock);
    werr <= 1'b0;
    end_err <= 1'b0;
    rd(IDX_FLAG_VIEW, 16'h0000, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 16'h0002, RESP_OKAY);
    chk("irq", irq, 1'b0);
    wr(IDX_STAT_HIGH, 16'h0000, RESP_OKAY);
    chk("bank", bank, 1'b0);
  endtask

  // ----
  // sequence, watchdog and verdict
  // ----
  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    t_reset;
    t_stage;
    t_erase;
    t_fault;
    end_sim;
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #20000;
    num_errors++;
    end_sim;
  end
endmodule

/* File: rtl/fps_erase_track.sv */
// bank 0 and per-sector status tracking across an erase
// assumes start and end arrive as one-cycle pulses from the controller
module fps_erase_track
  import fps_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_erase_start,
  input wire logic i_erase_end,
  input wire logic i_end_error,
  input wire logic [SECT_N-1:0] i_sector_fail,
  input wire logic i_suspend,
  input wire logic i_low_we,
  input wire logic [15:0] i_low_data,
  input wire logic i_high_we,
  input wire logic [15:0] i_high_data,
  output logic [SECT_N-1:0] o_sectors,
  output logic o_bank,
  output fps_erase_e o_state,
  output logic o_evt_ok,
  output logic o_evt_err,
  output logic o_evt_suspend_flag
);

  typedef struct packed
  {
    fps_erase_e state;
    logic [SECT_N-1:0] sectors;
    logic bank;
    logic evt_ok;
    logic evt_err;
    logic evt_suspend_flag;
  } fps_track_s;

  localparam fps_track_s TRACK_RST = '{state: FPS_IDLE,
    sectors: RST_SECTORS, default: '0};

  fps_track_s r_reg;
  fps_track_s r_next;

  always_comb
  begin
    r_next = r_reg;
    r_next.evt_ok = 1'b0;
    r_next.evt_err = 1'b0;
    r_next.evt_suspend_flag = 1'b0;
    case (r_reg.state)
      FPS_IDLE:
      begin
        if (i_erase_start)
        begin
          // selected sectors stay set and now report status
          r_next.state = FPS_ERASE;
          r_next.bank = 1'b1;
        end
        else
        begin
          // software owns the bits only between erases
          if (i_low_we)
          begin
            r_next.sectors = i_low_data[SECT_N-1:0];
          end
          if (i_high_we)
          begin
            r_next.bank = i_high_data[BANK0_BIT];
          end
        end
      end
      FPS_ERASE, FPS_SUSPEND_FLAG:
      begin
        // writes are dropped here so a careless store cannot mask status
        if (i_erase_end)
        begin
          r_next.state = FPS_IDLE;
          if (i_end_error)
          begin
            r_next.sectors = r_reg.sectors & i_sector_fail;
            r_next.bank = 1'b1;
            r_next.evt_err = 1'b1;
          end
          else
          begin
            r_next.sectors = '0;
            r_next.bank = 1'b0;
            r_next.evt_ok = 1'b1;
          end
        end
        else if (r_reg.state == FPS_ERASE && i_suspend)
        begin
          r_next.state = FPS_SUSPEND_FLAG;
          r_next.evt_suspend_flag = 1'b1;
        end
        else if (r_reg.state == FPS_SUSPEND_FLAG && !i_suspend)
        begin
          r_next.state = FPS_ERASE;
        end
      end
      default:
      begin
        r_next.state = FPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      r_reg <= TRACK_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign o_sectors = r_reg.sectors;
  assign o_bank = r_reg.bank;
  assign o_state = r_reg.state;
  assign o_evt_ok = r_reg.evt_ok;
  assign o_evt_err = r_reg.evt_err;
  assign o_evt_suspend_flag = r_reg.evt_suspend_flag;

  a_bank_busy: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    r_reg.state != FPS_IDLE |-> o_bank)
    else $error("bank status low during erase");

  a_clean_end: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    r_reg.state != FPS_IDLE && i_erase_end && !i_end_error
      |=> !o_bank && o_sectors == '0 && o_evt_ok)
    else $error("status not cleared after clean erase");

  a_fail_keep: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    r_reg.state != FPS_IDLE && i_erase_end && i_end_error
      |=> o_bank && o_sectors == ($past(o_sectors) & $past(i_sector_fail)))
    else $error("failing sectors not kept after erase");

  a_sw_select: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    r_reg.state == FPS_IDLE && !i_erase_start && i_low_we
      |=> o_sectors == $past(i_low_data[SECT_N-1:0]))
    else $error("sector select write not stored");

endmodule

/* File: rtl/fps_irq.sv */
// sticky event flags, write-one-to-clear, with a mask and one level irq
// assumes events are one-cycle pulses in the system clock domain
module fps_irq
  import fps_pkg::*;
#(
  parameter int N = IRQ_N
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [N-1:0] i_event,
  input wire logic [N-1:0] i_clear,
  input wire logic i_mask_we,
  input wire logic [N-1:0] i_mask_data,
  output logic [N-1:0] o_status,
  output logic [N-1:0] o_mask,
  output logic o_irq
);

  typedef struct packed
  {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } fps_irq_s;

  fps_irq_s r_reg;
  fps_irq_s r_next;

  always_comb
  begin
    r_next = r_reg;
    // a new event beats a clear in the same cycle
    r_next.status = (r_reg.status & ~i_clear) | i_event;
    if (i_mask_we)
    begin
      r_next.mask = i_mask_data;
    end
    r_next.irq = |(r_next.status & r_next.mask);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign o_status = r_reg.status;
  assign o_mask = r_reg.mask;
  assign o_irq = r_reg.irq;

  a_irq_set_wins: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_event & i_clear) != '0 |=> (o_status & $past(i_event & i_clear))
      == $past(i_event & i_clear))
    else $error("event lost against clear");

  a_irq_level: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_irq == |(o_status & o_mask))
    else $error("irq does not follow masked status");

endmodule

/* File: rtl/fps_pkg.sv */
// constants and types shared by the flash program staging block
// assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock
package fps_pkg;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam logic [19:0] IDX_STAT_LOW = 20'h8_0004;
  localparam logic [19:0] IDX_STAT_HIGH = 20'h8_0006;
  localparam logic [19:0] IDX_DATA_A_LOW = 20'h8_0008;
  localparam logic [19:0] IDX_DATA_A_HIGH = 20'h8_000a;
  localparam logic [19:0] IDX_DATA_B_LOW = 20'h8_000c;
  localparam logic [19:0] IDX_DATA_B_HIGH = 20'h8_000e;
  localparam logic [19:0] IDX_ADDR_LOW = 20'h8_0010;
  localparam logic [19:0] IDX_ADDR_HIGH = 20'h8_0012;
  localparam logic [19:0] IDX_FLAG_VIEW = 20'h8_0014;
  localparam logic [19:0] IDX_IRQ_STATUS = 20'h8_0016;
  localparam logic [19:0] IDX_IRQ_MASK = 20'h8_0018;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_DATA = 16'hffff;
  localparam logic [15:0] RST_ADDR_LOW = 16'h0000;
  localparam logic [4:0] RST_ADDR_HIGH = 5'h00;
  localparam logic [7:0] RST_SECTORS = 8'h00;
  localparam int BANK0_BIT = 8;
  localparam int SECT_N = 8;
  localparam int ADDR_HIGH_W = 5;
  localparam int ADDR_LOW_LSB = 2;
  localparam int IRQ_N = 3;
  localparam int IRQ_DONE_OK = 0;
  localparam int IRQ_DONE_ERR = 1;
  localparam int IRQ_SUSPEND_FLAG = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    FPS_IDLE = 2'b00,
    FPS_ERASE = 2'b01,
    FPS_SUSPEND_FLAG = 2'b11
  } fps_erase_e;

  typedef enum logic [1:0]
  {
    FPS_MEAN_NONE = 2'b00,
    FPS_MEAN_ERROR = 2'b01,
    FPS_MEAN_SUSPEND_FLAG = 2'b10
  } fps_mean_e;

endpackage

/* File: rtl/fps_staging.sv */
// top of the flash program staging block: AXI4-Lite slave, data and
// address staging, erase status view, flag meaning and interrupt
// assumes the flash controller drives the erase pulses and flag levels
// synchronously to i_clock
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module fps_staging
  import fps_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_erase_start,
  input wire logic i_erase_end,
  input wire logic i_end_error,
  input wire logic [SECT_N-1:0] i_sector_fail,
  input wire logic i_write_error,
  input wire logic i_suspend,
  output logic [20:0] o_prog_address,
  output logic [63:0] o_prog_data,
  output logic [SECT_N-1:0] o_sector_select,
  output logic o_bank0_state,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(logic [ADDR_W-1:0] a, logic [19:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic [15:0] merge16(logic [15:0] old,
    logic [31:0] d, logic [3:0] strb);
    merge16[7:0] = strb[0] ? d[7:0] : old[7:0];
    merge16[15:8] = strb[1] ? d[15:8] : old[15:8];
  endfunction

  function automatic fps_mean_e meaning(logic err, logic suspend_flag);
    if (err)
    begin
      meaning = FPS_MEAN_ERROR;
    end
    else if (suspend_flag)
    begin
      meaning = FPS_MEAN_SUSPEND_FLAG;
    end
    else
    begin
      meaning = FPS_MEAN_NONE;
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_ready;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_ready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_ready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] data_a_low;
    logic [15:0] data_a_high;
    logic [15:0] data_b_low;
    logic [15:0] data_b_high;
    logic [15:0] addr_low;
    logic [ADDR_HIGH_W-1:0] addr_high;
    logic err_flag;
    logic suspend_flag_flag;
    fps_mean_e mean;
  } fps_top_s;

  localparam fps_top_s TOP_RST = '{data_a_low: RST_DATA,
    data_a_high: RST_DATA, data_b_low: RST_DATA, data_b_high: RST_DATA,
    addr_low: RST_ADDR_LOW, addr_high: RST_ADDR_HIGH,
    mean: FPS_MEAN_NONE, default: '0};

  fps_top_s r_reg;
  fps_top_s r_next;

  logic wr_go;
  logic stat_low_we;
  logic stat_high_we;
  logic irq_mask_we;
  logic [IRQ_N-1:0] irq_clear;
  logic [15:0] wr_low16;
  logic [SECT_N-1:0] sectors;
  logic bank;
  fps_erase_e erase_state;
  logic evt_ok;
  logic evt_err;
  logic evt_suspend_flag;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_mask;
  logic irq;
  logic [15:0] stat_low_view;
  logic [15:0] stat_high_view;

  assign stat_low_view = {{(16 - SECT_N){1'b0}}, sectors};
  assign stat_high_view = 16'(bank) << BANK0_BIT;

  // ---------------------------------------------------------------
  // write decode toward the submodules
  // ---------------------------------------------------------------
  // the write lands once both address and data are held
  assign wr_go = r_reg.aw_full && r_reg.w_full;
  assign wr_low16 = merge16(16'h0000, r_reg.w_data, r_reg.w_strb);

  always_comb
  begin
    stat_low_we = 1'b0;
    stat_high_we = 1'b0;
    irq_mask_we = 1'b0;
    irq_clear = '0;
    if (!wr_go)
    begin
      stat_low_we = 1'b0;
    end
    else if (hit(r_reg.aw_addr, IDX_STAT_LOW))
    begin
      stat_low_we = 1'b1;
    end
    else if (hit(r_reg.aw_addr, IDX_STAT_HIGH))
    begin
      stat_high_we = 1'b1;
    end
    else if (hit(r_reg.aw_addr, IDX_IRQ_STATUS))
    begin
      irq_clear = wr_low16[IRQ_N-1:0];
    end
    else if (hit(r_reg.aw_addr, IDX_IRQ_MASK))
    begin
      irq_mask_we = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bus and staging registers
  // ---------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    // flag levels are sampled so the reported meaning is registered
    r_next.err_flag = i_write_error;
    r_next.suspend_flag_flag = i_suspend;
    r_next.mean = meaning(i_write_error, i_suspend);
    if (o_s_axi_awready && i_s_axi_awvalid)
    begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = i_s_axi_awaddr;
    end
    if (o_s_axi_wready && i_s_axi_wvalid)
    begin
      r_next.w_full = 1'b1;
      r_next.w_data = i_s_axi_wdata;
      r_next.w_strb = i_s_axi_wstrb;
    end
    if (r_reg.bvalid && i_s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      r_next.aw_full = 1'b0;
      r_next.w_full = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      if (hit(r_reg.aw_addr, IDX_DATA_A_LOW))
      begin
        r_next.data_a_low = merge16(r_reg.data_a_low, r_reg.w_data,
          r_reg.w_strb);
      end
      else if (hit(r_reg.aw_addr, IDX_DATA_A_HIGH))
      begin
        r_next.data_a_high = merge16(r_reg.data_a_high, r_reg.w_data,
          r_reg.w_strb);
      end
      else if (hit(r_reg.aw_addr, IDX_DATA_B_LOW))
      begin
        r_next.data_b_low = merge16(r_reg.data_b_low, r_reg.w_data,
          r_reg.w_strb);
      end
      else if (hit(r_reg.aw_addr, IDX_DATA_B_HIGH))
      begin
        r_next.data_b_high = merge16(r_reg.data_b_high, r_reg.w_data,
          r_reg.w_strb);
      end
      else if (hit(r_reg.aw_addr, IDX_ADDR_LOW))
      begin
        // low two bits are reserved and always read zero
        r_next.addr_low = merge16(r_reg.addr_low, r_reg.w_data,
          r_reg.w_strb) & ~16'h0003;
      end
      else if (hit(r_reg.aw_addr, IDX_ADDR_HIGH))
      begin
        r_next.addr_high = wr_low16[ADDR_HIGH_W-1:0];
      end
      else if (!(stat_low_we || stat_high_we || irq_mask_we
        || hit(r_reg.aw_addr, IDX_IRQ_STATUS)
        || hit(r_reg.aw_addr, IDX_FLAG_VIEW)))
      begin
        r_next.bresp = RESP_SLVERR;
      end
    end
    if (r_reg.rvalid && i_s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
    end
    if (o_s_axi_arready && i_s_axi_arvalid)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      r_next.rdata = '0;
      if (hit(i_s_axi_araddr, IDX_STAT_LOW))
      begin
        r_next.rdata[15:0] = stat_low_view;
      end
      else if (hit(i_s_axi_araddr, IDX_STAT_HIGH))
      begin
        r_next.rdata[15:0] = stat_high_view;
      end
      else if (hit(i_s_axi_araddr, IDX_DATA_A_LOW))
      begin
        r_next.rdata[15:0] = r_reg.data_a_low;
      end
      else if (hit(i_s_axi_araddr, IDX_DATA_A_HIGH))
      begin
        r_next.rdata[15:0] = r_reg.data_a_high;
      end
      else if (hit(i_s_axi_araddr, IDX_DATA_B_LOW))
      begin
        r_next.rdata[15:0] = r_reg.data_b_low;
      end
      else if (hit(i_s_axi_araddr, IDX_DATA_B_HIGH))
      begin
        r_next.rdata[15:0] = r_reg.data_b_high;
      end
      else if (hit(i_s_axi_araddr, IDX_ADDR_LOW))
      begin
        r_next.rdata[15:0] = r_reg.addr_low;
      end
      else if (hit(i_s_axi_araddr, IDX_ADDR_HIGH))
      begin
        r_next.rdata[ADDR_HIGH_W-1:0] = r_reg.addr_high;
      end
      else if (hit(i_s_axi_araddr, IDX_FLAG_VIEW))
      begin
        r_next.rdata[3:0] = {r_reg.mean, r_reg.suspend_flag_flag, r_reg.err_flag};
      end
      else if (hit(i_s_axi_araddr, IDX_IRQ_STATUS))
      begin
        r_next.rdata[IRQ_N-1:0] = irq_status;
      end
      else if (hit(i_s_axi_araddr, IDX_IRQ_MASK))
      begin
        r_next.rdata[IRQ_N-1:0] = irq_mask;
      end
      else
      begin
        r_next.rresp = RESP_SLVERR;
      end
    end
    // one transfer of each kind at a time
    r_next.aw_ready = !r_next.aw_full && !r_next.bvalid;
    r_next.w_ready = !r_next.w_full && !r_next.bvalid;
    r_next.ar_ready = !r_next.rvalid;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      r_reg <= TOP_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  fps_erase_track u_track
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_erase_start(i_erase_start),
    .i_erase_end(i_erase_end),
    .i_end_error(i_end_error),
    .i_sector_fail(i_sector_fail),
    .i_suspend(i_suspend),
    .i_low_we(stat_low_we),
    .i_low_data(merge16(stat_low_view, r_reg.w_data, r_reg.w_strb)),
    .i_high_we(stat_high_we),
    .i_high_data(merge16(stat_high_view, r_reg.w_data, r_reg.w_strb)),
    .o_sectors(sectors),
    .o_bank(bank),
    .o_state(erase_state),
    .o_evt_ok(evt_ok),
    .o_evt_err(evt_err),
    .o_evt_suspend_flag(evt_suspend_flag)
  );

  fps_irq #(.N(IRQ_N)) u_irq
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_event({evt_suspend_flag, evt_err, evt_ok}),
    .i_clear(irq_clear),
    .i_mask_we(irq_mask_we),
    .i_mask_data(wr_low16[IRQ_N-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(irq)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_s_axi_awready = r_reg.aw_ready;
  assign o_s_axi_wready = r_reg.w_ready;
  assign o_s_axi_bvalid = r_reg.bvalid;
  assign o_s_axi_bresp = r_reg.bresp;
  assign o_s_axi_arready = r_reg.ar_ready;
  assign o_s_axi_rvalid = r_reg.rvalid;
  assign o_s_axi_rdata = r_reg.rdata;
  assign o_s_axi_rresp = r_reg.rresp;
  // target bit two is passed as written; the controller checks alignment
  assign o_prog_address = {r_reg.addr_high,
    r_reg.addr_low[15:ADDR_LOW_LSB], 2'b00};
  // even word in the low half, odd word in the high half
  assign o_prog_data = {r_reg.data_b_high, r_reg.data_b_low,
    r_reg.data_a_high, r_reg.data_a_low};
  assign o_sector_select = sectors;
  assign o_bank0_state = bank;
  assign o_irq = irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_data_b_reset: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $past(i_sys_rst) |-> r_reg.data_b_low == RST_DATA
      && r_reg.data_b_high == RST_DATA)
    else $error("second data pair not all ones after reset");

  a_addr_reset: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $past(i_sys_rst) |-> r_reg.addr_low == RST_ADDR_LOW)
    else $error("low address not zero after reset");

  a_data_b_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    wr_go && hit(r_reg.aw_addr, IDX_DATA_B_HIGH) && r_reg.w_strb[1:0] == 2'b11
      |=> r_reg.data_b_high == $past(r_reg.w_data[15:0]) && r_reg.bvalid)
    else $error("second data high half not written");

  a_mean_error: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_write_error |=> r_reg.mean == FPS_MEAN_ERROR)
    else $error("error flag not shown as erase error");

  a_mean_suspend_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_write_error && i_suspend |=> r_reg.mean == FPS_MEAN_SUSPEND_FLAG)
    else $error("suspend flag not shown as suspended");

endmodule
